//--- core/byte_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes push and pop run on the same clock.
*/
`timescale 1ns/1ps
module byte_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic     ref_clk,
  input  wire logic     rst,
  // streams
  byte_stream_if.dst    push,
  byte_stream_if.src    pop
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0]             wp;
    logic [AW:0]             rp;
  } fifo_t;

  fifo_t r_reg;
  fifo_t r_next;
  logic  full;
  logic  empty;

  // extra pointer bit tells full from empty
  assign empty = (r_reg.wp == r_reg.rp);
  assign full  = (r_reg.wp[AW-1:0] == r_reg.rp[AW-1:0]) && !empty;
  assign push.ready = !full;
  assign pop.valid  = !empty;
  assign pop.data   = r_reg.mem[r_reg.rp[AW-1:0]];

  always_comb begin
    r_next = r_reg;
    if (push.valid && !full) begin
      r_next.mem[r_reg.wp[AW-1:0]] = push.data;
      r_next.wp = r_reg.wp + 1'b1;
    end
    if (pop.ready && !empty) r_next.rp = r_reg.rp + 1'b1;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) r_reg <= '0;
    else r_reg <= r_next;
  end
endmodule

//--- core/ee_page_write.sv
/*
  Page write and write-protect core of a serial EEPROM. Bytes arrive from
  the serial shifter, cross into the core clock through a toggle, queue in
  a FIFO, and fill a one-page buffer that is committed to an external
  array port once select rises. Assumes the array port takes one byte per
  cycle in which both write strobe and ready are high.
*/
`timescale 1ns/1ps
// Function
// - write: command, 16-bit address, data bytes
// - one write touches at most one page
// - address wraps within the same page
// - overflowing bytes overwrite, last 32 kept
// - guarded region never written
// - array writes need write latch set
// - finished array write clears write latch
// - hardware protect ignored for array writes
// - hardware protect: arm bit 1, pin 0
// - status bits change only latch on, unprotected
// - only address bits 9..0 decoded
// - write opcode 0000x010, msb first, rising edge
// - busy: status reads all ones, commands ignored
// - guard bits pick none, top quarter, half, all
module ee_page_write #(
  parameter int WC_CYCLES = ee_pkg::WC_CYCLES,
  parameter int FIFO_W    = 8,
  parameter int FIFO_D    = ee_pkg::FIFO_DEPTH
) (
  // core clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // serial link from host
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  // hardware protect pin
  input  wire logic       wp_n,
  // array write port
  output logic            arr_we,
  output logic [9:0]      arr_addr,
  output logic [7:0]      arr_wdata,
  input  wire logic       arr_ready,
  // status
  output logic [7:0]      status_byte,
  output logic            busy,
  output logic            hw_protect_on,
  output logic            rx_fifo_ready
);
  localparam int TW = $clog2(WC_CYCLES + 1);

  typedef struct packed {
    ee_pkg::phase_t              ph;
    ee_pkg::op_t                 op;
    logic [2:0]                  cs_s;
    logic [2:0]                  tg_s;
    logic [1:0]                  wp_s;
    logic [9:0]                  addr;
    logic [31:0][7:0]            pg;
    logic [31:0]                 vld;
    logic                        got;
    logic                        endp;
    logic                        wel;
    logic                        arm;
    logic                        glo;
    logic                        ghi;
    logic [7:0]                  sdat;
    logic [4:0]                  idx;
    logic [TW-1:0]               tmr;
  } core_t;

  core_t       r_reg;
  core_t       r_next;
  logic [7:0]  rx_byte;
  logic        rx_tgl;
  logic        cs_rise;
  logic        cs_fall;
  logic        take;
  logic        hit;
  logic        collecting;
  logic [9:0]  cur_addr;

  byte_stream_if #(.W(FIFO_W)) in_if ();
  byte_stream_if #(.W(FIFO_W)) out_if ();

  spi_byte_rx u_rx (
    .sck     (sck),
    .cs_n    (cs_n),
    .mosi    (mosi),
    .rst     (rst),
    .rx_byte (rx_byte),
    .rx_tgl  (rx_tgl)
  );

  byte_fifo #(.W(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
    .ref_clk (ref_clk),
    .rst     (rst),
    .push    (in_if.dst),
    .pop     (out_if.src)
  );

  // edges seen only after the second synchroniser flop
  assign cs_rise = r_reg.cs_s[1] && !r_reg.cs_s[2];
  assign cs_fall = !r_reg.cs_s[1] && r_reg.cs_s[2];

  // byte word is stable for a whole byte time when its toggle lands
  assign in_if.valid   = r_reg.tg_s[2] ^ r_reg.tg_s[1];
  assign in_if.data    = rx_byte;
  assign rx_fifo_ready = in_if.ready;

  // fifo stalls while the page buffer is being committed
  assign out_if.ready = (r_reg.ph != ee_pkg::PH_COMMIT);
  assign take         = out_if.valid && out_if.ready;

  assign collecting = (r_reg.ph inside {ee_pkg::PH_CMD, ee_pkg::PH_ADDR_HI,
                       ee_pkg::PH_ADDR_LO, ee_pkg::PH_DATA, ee_pkg::PH_SKIP});

  // commit address keeps the page, walks the offset
  assign cur_addr = {r_reg.addr[9:5], r_reg.idx};
  assign hit = r_reg.vld[r_reg.idx]
               && !ee_pkg::guarded({r_reg.ghi, r_reg.glo}, cur_addr);

  // array port; protect pin has no say here
  assign arr_we    = (r_reg.ph == ee_pkg::PH_COMMIT) && hit;
  assign arr_addr  = cur_addr;
  assign arr_wdata = r_reg.pg[r_reg.idx];

  assign busy = (r_reg.ph == ee_pkg::PH_COMMIT) || (r_reg.ph == ee_pkg::PH_WAIT);
  assign hw_protect_on = r_reg.arm && !r_reg.wp_s[1];

  // all ones while an internal cycle runs
  always_comb begin
    status_byte                  = 8'h00;
    status_byte[ee_pkg::ST_LATCH] = r_reg.wel;
    status_byte[ee_pkg::ST_GLO]  = r_reg.glo;
    status_byte[ee_pkg::ST_GHI]  = r_reg.ghi;
    status_byte[ee_pkg::ST_ARM]  = r_reg.arm;
    if (busy) status_byte = ee_pkg::STATUS_BUSY;
  end

  always_comb begin
    r_next      = r_reg;
    r_next.cs_s = {r_reg.cs_s[1:0], cs_n};
    r_next.tg_s = {r_reg.tg_s[1:0], rx_tgl};
    r_next.wp_s = {r_reg.wp_s[0], wp_n};
    // select high ends the transaction
    if (cs_rise && collecting) r_next.endp = 1'b1;
    case (r_reg.ph)
      ee_pkg::PH_IDLE: begin
        // new command only when idle; busy drops whole transactions
        if (cs_fall) begin
          r_next.ph   = ee_pkg::PH_CMD;
          r_next.op   = ee_pkg::OP_NONE;
          r_next.vld  = '0;
          r_next.got  = 1'b0;
          r_next.endp = 1'b0;
        end
      end
      ee_pkg::PH_CMD: begin
        if (take) begin
          r_next.ph = ee_pkg::PH_SKIP;
          case (out_if.data & ee_pkg::CMD_MASK)
            ee_pkg::CMD_WRITE: begin
              r_next.op = ee_pkg::OP_WRITE;
              r_next.ph = ee_pkg::PH_ADDR_HI;
            end
            ee_pkg::CMD_SET_LATCH: r_next.op = ee_pkg::OP_SET;
            ee_pkg::CMD_CLR_LATCH: r_next.op = ee_pkg::OP_CLR;
            ee_pkg::CMD_STAT_WR:   r_next.op = ee_pkg::OP_STAT_WR;
            default:               r_next.op = ee_pkg::OP_NONE;
          endcase
        end
      end
      ee_pkg::PH_ADDR_HI: begin
        // bits 15..10 dropped
        if (take) begin
          r_next.addr[9:8] = out_if.data[ee_pkg::ADDR_HI_W-1:0];
          r_next.ph        = ee_pkg::PH_ADDR_LO;
        end
      end
      ee_pkg::PH_ADDR_LO: begin
        if (take) begin
          r_next.addr[7:0] = out_if.data;
          r_next.ph        = ee_pkg::PH_DATA;
        end
      end
      ee_pkg::PH_DATA: begin
        // later bytes overwrite earlier ones on the same slot
        if (take) begin
          r_next.pg[r_reg.addr[4:0]]  = out_if.data;
          r_next.vld[r_reg.addr[4:0]] = 1'b1;
          r_next.got                  = 1'b1;
          // low five bits wrap, page bits untouched
          r_next.addr[4:0] = r_reg.addr[4:0] + 5'h01;
        end
      end
      ee_pkg::PH_SKIP: begin
        // first data byte kept for a status write
        if (take && !r_reg.got) begin
          r_next.sdat = out_if.data;
          r_next.got  = 1'b1;
        end
      end
      ee_pkg::PH_COMMIT: begin
        if (!hit || arr_ready) begin
          r_next.idx = r_reg.idx + 5'h01;
          if (r_reg.idx == 5'h1f) begin
            r_next.wel = 1'b0;
            r_next.tmr = TW'(WC_CYCLES - 1);
            r_next.ph  = ee_pkg::PH_WAIT;
          end
        end
      end
      ee_pkg::PH_WAIT: begin
        // self-timed cycle; bytes that arrive are drained and dropped
        r_next.tmr = r_reg.tmr - 1'b1;
        if (r_reg.tmr == '0) r_next.ph = ee_pkg::PH_IDLE;
      end
      default: r_next.ph = ee_pkg::PH_IDLE;
    endcase
    // act once every queued byte of the transaction is consumed
    if (collecting && r_reg.endp && !out_if.valid) begin
      r_next.endp = 1'b0;
      r_next.ph   = ee_pkg::PH_IDLE;
      case (r_reg.op)
        ee_pkg::OP_SET: r_next.wel = 1'b1;
        ee_pkg::OP_CLR: r_next.wel = 1'b0;
        ee_pkg::OP_STAT_WR: begin
          // refused writes leave latch and bits alone
          if (r_reg.got && r_reg.wel && !hw_protect_on) begin
            r_next.arm = r_reg.sdat[ee_pkg::ST_ARM];
            r_next.ghi = r_reg.sdat[ee_pkg::ST_GHI];
            r_next.glo = r_reg.sdat[ee_pkg::ST_GLO];
            r_next.wel = 1'b0;
            r_next.tmr = TW'(WC_CYCLES - 1);
            r_next.ph  = ee_pkg::PH_WAIT;
          end
        end
        ee_pkg::OP_WRITE: begin
          // latch off means the whole array is read-only
          if (r_reg.got && r_reg.wel) begin
            r_next.idx = 5'h00;
            r_next.ph  = ee_pkg::PH_COMMIT;
          end
        end
        default: r_next.ph = ee_pkg::PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) r_reg <= '0;
    else r_reg <= r_next;
  end

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_busy_all_ones: assert property (
    busy |-> (status_byte == ee_pkg::STATUS_BUSY) ##1 !collecting
  ) else $error("status not all ones or command taken while busy");

  a_guard_never_written: assert property (
    arr_we |-> !ee_pkg::guarded({r_reg.ghi, r_reg.glo}, arr_addr)
  ) else $error("write into guarded range");

  a_write_needs_latch: assert property (
    arr_we |-> r_reg.wel
  ) else $error("array write with latch clear");

  a_latch_cleared_after: assert property (
    $fell(busy) |-> !r_reg.wel && !status_byte[ee_pkg::ST_LATCH]
  ) else $error("latch still set after write cycle");

  a_page_held: assert property (
    arr_we ##1 arr_we |-> arr_addr[9:5] == $past(arr_addr[9:5])
  ) else $error("commit left its page");

  a_page_wrap: assert property (
    (take && r_reg.ph == ee_pkg::PH_DATA && r_reg.addr[4:0] == 5'h1f)
    |=> r_reg.addr[4:0] == 5'h00 && $stable(r_reg.addr[9:5])
  ) else $error("page address did not wrap");

  a_protect_level: assert property (
    hw_protect_on == (r_reg.arm && !$past(wp_n, 2))
  ) else $error("hardware protect level wrong");

  a_status_locked: assert property (
    (hw_protect_on || !r_reg.wel) |=> $stable({r_reg.arm, r_reg.ghi, r_reg.glo})
  ) else $error("status bits changed while locked");

  a_busy_span: assert property (
    $rose(busy) |-> busy [*4]
  ) else $error("write cycle ended too soon");
endmodule

//--- core/spi_byte_rx.sv
/*
  Serial shifter on the host's serial clock. Collects bytes msb first
  and flags each with a toggle. Assumes select high holds the clock still.
*/
`timescale 1ns/1ps
module spi_byte_rx (
  // link side
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  input  wire logic       rst,
  // core side
  output logic [7:0]      rx_byte,
  output logic            rx_tgl
);
  typedef struct packed {
    logic [6:0] sh;
    logic [7:0] byte_q;
    logic       tgl;
  } rx_t;

  rx_t        r_reg;
  rx_t        r_next;
  logic [2:0] cnt_reg;

  // bit count restarts with every select; partial bytes are lost
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) cnt_reg <= 3'h0;
    else cnt_reg <= cnt_reg + 3'h1;
  end

  // sample on rising edge, msb first
  always_comb begin
    r_next    = r_reg;
    r_next.sh = {r_reg.sh[5:0], mosi};
    if (cnt_reg == 3'h7) begin
      r_next.byte_q = {r_reg.sh, mosi};
      r_next.tgl    = ~r_reg.tgl;
    end
  end

  // toggle survives select so no byte event is lost
  always_ff @(posedge sck or posedge rst) begin
    if (rst) r_reg <= '0;
    else r_reg <= r_next;
  end

  assign rx_byte = r_reg.byte_q;
  assign rx_tgl  = r_reg.tgl;
endmodule

//--- dv/spi_eeprom_page_write_protect_bench.sv
/*
  Self-checking bench for the page-write and write-protect core.
  Assumes a behavioural link host and an array that stalls every 4th cycle.
*/
`timescale 1ns/1ps
module spi_eeprom_page_write_protect_bench;
  localparam int WC = 400;
  typedef struct packed {
    logic [1:0]  guard;
    logic        latch;
    logic [15:0] addr;
    logic [7:0]  n;
    logic        kept;
  } row_t;

  logic       ref_clk = 1'b0;
  logic       rst;
  logic       wp_n;
  logic       arr_ready;
  logic [1:0] stall_cnt = 2'h0;
  logic       sck, cs_n, mosi, arr_we, busy, hw_protect_on, rx_fifo_ready;
  logic [9:0] arr_addr;
  logic [7:0] arr_wdata, status_byte;
  logic [7:0] mem [1024];
  logic [7:0] exp_mem [1024];
  logic [1:0] cur_guard = 2'h0;
  int         n_fail = 0;
  int         total_checks = 0;
  int         run_len = 0;
  int         last_run = 0;

  // ordinary cases: guard setting, latch, address, count, array kept
  row_t rows [9] = '{
    '{2'h0, 1'b1, 16'h0010, 8'h03, 1'b1}, '{2'h0, 1'b1, 16'hfc1e, 8'h04, 1'b1},
    '{2'h0, 1'b1, 16'h0040, 8'h28, 1'b1}, '{2'h0, 1'b0, 16'h0080, 8'h02, 1'b0},
    '{2'h1, 1'b1, 16'h02f0, 8'h02, 1'b1}, '{2'h1, 1'b1, 16'h0300, 8'h02, 1'b0},
    '{2'h2, 1'b1, 16'h0200, 8'h02, 1'b0}, '{2'h2, 1'b1, 16'h01fe, 8'h02, 1'b1},
    '{2'h3, 1'b1, 16'h0000, 8'h02, 1'b0}};

  always #2.5 ref_clk = ~ref_clk;

  spi_host_model u_host (.sck(sck), .cs_n(cs_n), .mosi(mosi));

  ee_page_write #(.WC_CYCLES(WC)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .sck(sck), .cs_n(cs_n), .mosi(mosi), .wp_n(wp_n),
    .arr_we(arr_we), .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_ready(arr_ready),
    .status_byte(status_byte), .busy(busy), .hw_protect_on(hw_protect_on),
    .rx_fifo_ready(rx_fifo_ready));

  // array stalls one cycle in four so the write strobe must hold
  always @(negedge ref_clk) begin
    stall_cnt <= stall_cnt + 2'h1;
  end
  assign arr_ready = (stall_cnt != 2'h3);

  // array model and busy length measure
  always @(posedge ref_clk) begin
    if (arr_we === 1'b1 && arr_ready) mem[arr_addr] <= arr_wdata;
    if (busy === 1'b1) run_len <= run_len + 1;
    else begin
      if (run_len != 0) last_run <= run_len;
      run_len <= 0;
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // let the select edge cross, then wait out any busy cycle
  task automatic settle();
    int k;
    k = 0;
    repeat (20) @(negedge ref_clk);
    while (busy !== 1'b0 && k < 3000) begin
      @(negedge ref_clk);
      k++;
    end
    if (k == 3000) chk("busy end", 8'h00, 8'h01);
    // one more cycle so the busy length of this run is recorded
    @(negedge ref_clk);
  endtask

  task automatic latch_on();
    u_host.put(8'h06); // host sets the latch before modifying
    u_host.frame();
    settle();
  endtask

  task automatic wr_status(input logic [7:0] d);
    u_host.put(8'h01);
    u_host.put(d);
    u_host.frame();
    settle();
  endtask

  // array write of n bytes from seed; kept says the array should change
  task automatic arr_write(input logic [15:0] a, input int n, input logic [7:0] seed,
                           input logic kept);
    logic [9:0] ix;
    u_host.put(8'h02);
    u_host.put(a[15:8]);
    u_host.put(a[7:0]);
    for (int k = 0; k < n; k++) begin
      u_host.put(8'(seed + k));
      if (kept) exp_mem[{a[9:5], 5'(a[4:0] + k)}] = 8'(seed + k);
    end
    u_host.frame();
    settle();
    for (int j = 0; j < 32; j++) begin
      ix = {a[9:5], 5'(j)};
      chk("page", exp_mem[ix], mem[ix]);
    end
  endtask

  task automatic final_report();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // watchdog reckoned well past the roughly 200 us of traffic
  initial begin
    #450000;
    chk("watchdog", 8'h00, 8'h01);
    final_report();
  end

  initial begin
    rst = 1'b1;
    wp_n = 1'b1;
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 8'h00;
      exp_mem[i] = 8'h00;
    end
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    repeat (8) @(negedge ref_clk);
    chk("status after reset", 8'h00, status_byte);
    chk("fifo ready after reset", 8'h01, {7'h0, rx_fifo_ready});
    // table of ordinary cases
    for (int r = 0; r < 9; r++) begin
      if (rows[r].guard != cur_guard) begin
        latch_on();
        wr_status({4'h0, rows[r].guard, 2'b00});
        cur_guard = rows[r].guard;
        chk("guard status", {4'h0, cur_guard, 2'b00}, status_byte);
      end
      if (rows[r].latch) latch_on();
      arr_write(rows[r].addr, int'(rows[r].n), 8'(r * 64 + 1), rows[r].kept);
      chk("latch after write", 8'h00, {7'h0, status_byte[1]});
      $display("row %0d done", r);
    end
    // busy window: all ones, commands dropped, timed length
    latch_on();
    wr_status(8'h00);
    latch_on();
    u_host.put(8'h02);
    u_host.put(8'hfd); // upper six address bits must be ignored
    u_host.put(8'h00);
    u_host.put(8'h5a);
    u_host.frame();
    chk("busy flag", 8'h01, {7'h0, busy});
    chk("status while busy", 8'hff, status_byte);
    u_host.put(8'h0e);
    u_host.frame();
    settle();
    chk("write data", 8'h5a, mem[10'h100]);
    chk("busy min", 8'h01, {7'h0, last_run >= WC + 32});
    chk("busy max", 8'h01, {7'h0, last_run <= WC + 40});
    chk("latch after busy cmd", 8'h00, status_byte);
    $display("busy test done");
    // hardware protect: arm bit with pin low
    latch_on();
    wr_status(8'h80);
    chk("armed status", 8'h80, status_byte);
    chk("protect pin high", 8'h00, {7'h0, hw_protect_on});
    wp_n = 1'b0;
    repeat (6) @(negedge ref_clk);
    chk("protect active", 8'h01, {7'h0, hw_protect_on});
    latch_on();
    arr_write(16'h0120, 1, 8'h3c, 1'b1);
    latch_on();
    wr_status(8'h0c);
    chk("status refused", 8'h82, status_byte);
    u_host.put(8'h04);
    u_host.frame();
    settle();
    chk("latch cleared", 8'h80, status_byte);
    wp_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    chk("protect released", 8'h00, {7'h0, hw_protect_on});
    latch_on();
    wr_status(8'h00);
    chk("disarmed status", 8'h00, status_byte);
    $display("protect test done");
    // mid-run reset drops the latch; the link must work again after it
    latch_on();
    chk("latch before reset", 8'h02, status_byte);
    rst = 1'b1;
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    repeat (8) @(negedge ref_clk);
    chk("status after second reset", 8'h00, status_byte);
    chk("fifo ready after second reset", 8'h01, {7'h0, rx_fifo_ready});
    latch_on();
    arr_write(16'h0150, 1, 8'h77, 1'b1);
    chk("latch after reset write", 8'h00, status_byte);
    $display("reset test done");
    final_report();
  end
endmodule

//--- dv/spi_host_model.sv
/*
  Behavioural host on the serial link. It frames bytes msb first on its
  own 160 ns clock.
  Assumes the bench queues bytes with put and then calls frame.
*/
`timescale 1ns/1ps
module spi_host_model (
  // serial link toward the device
  output logic sck,
  output logic cs_n,
  output logic mosi
);
  logic [7:0] tx_q [$];

  // idle: select high, clock low, data parked
  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // queue one byte for the next frame
  task automatic put(input logic [7:0] b);
    tx_q.push_back(b);
  endtask

  // one transaction; the clock only toggles while selected
  task automatic frame();
    logic [7:0] b;
    #13; // odd offset keeps the link out of phase with the core clock
    cs_n = 1'b0;
    #80;
    while (tx_q.size() > 0) begin
      b = tx_q.pop_front();
      for (int i = 7; i >= 0; i--) begin
        mosi = b[i]; // msb first, set up while clock low
        #80 sck = 1'b1;
        #80 sck = 1'b0;
      end
    end
    #80 cs_n = 1'b1; // select rises before any further clock rise
    mosi = ~mosi; // a released line must not look like a held bit
    #200;
  endtask
endmodule

//--- shared/byte_stream_if.sv
/*
  Valid/ready byte stream between the core and its FIFO.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
interface byte_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface

//--- shared/ee_pkg.sv
/*
  Shared constants and types for the serial EEPROM page-write and
  write-protect logic. Assumes a 200 MHz core clock.
*/
package ee_pkg;
  // opcodes, bit 3 is don't care
  localparam logic [7:0] CMD_MASK      = 8'hf7;
  localparam logic [7:0] CMD_WRITE     = 8'h02;
  localparam logic [7:0] CMD_SET_LATCH = 8'h06;
  localparam logic [7:0] CMD_CLR_LATCH = 8'h04;
  localparam logic [7:0] CMD_STAT_WR   = 8'h01;
  // array and page geometry
  localparam int ADDR_W     = 10;
  localparam int PAGE_W     = 5;
  localparam int PAGE_BYTES = 32;
  localparam int ADDR_HI_W  = 2;
  // status bit positions and busy pattern
  localparam int ST_BUSY  = 0;
  localparam int ST_LATCH = 1;
  localparam int ST_GLO   = 2;
  localparam int ST_GHI   = 3;
  localparam int ST_ARM   = 7;
  localparam logic [7:0] STATUS_BUSY = 8'hff;
  // protected range bases
  localparam logic [9:0] GUARD_QTR  = 10'h300;
  localparam logic [9:0] GUARD_HALF = 10'h200;
  // write cycle time
  localparam int T_WC_NS   = 5000000;
  localparam int CLK_NS    = 5;
  localparam int WC_CYCLES = T_WC_NS / CLK_NS;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000, PH_CMD = 3'b001, PH_ADDR_HI = 3'b010,
    PH_ADDR_LO = 3'b011, PH_DATA = 3'b100, PH_SKIP = 3'b101,
    PH_COMMIT = 3'b110, PH_WAIT = 3'b111
  } phase_t;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000, OP_WRITE = 3'b001, OP_SET = 3'b010,
    OP_CLR = 3'b011, OP_STAT_WR = 3'b100
  } op_t;

  // true when the block guard setting covers the address
  function automatic logic guarded(input logic [1:0] g, input logic [9:0] a);
    case (g)
      2'b00:   guarded = 1'b0;
      2'b01:   guarded = (a >= GUARD_QTR);
      2'b10:   guarded = (a >= GUARD_HALF);
      default: guarded = 1'b1;
    endcase
  endfunction
endpackage
